// File: mmdec_map.svh
/*
 Address map, segment sizes and reset values for the memory map decoder.
 Included by the RAM power and decoder files, not by the package; definitions only.
*/
`ifndef MMDEC_MAP_SVH
`define MMDEC_MAP_SVH

`define MMDEC_PERIPH_LO   16'h0000
`define MMDEC_PERIPH_HI   16'h0fff
`define MMDEC_BOOT_LO     16'h1000
`define MMDEC_BOOT_HI     16'h17ff
`define MMDEC_INFO_LO     16'h1800
`define MMDEC_INFO_HI     16'h19ff
`define MMDEC_DESC_LO     16'h1a00
`define MMDEC_DESC_HI     16'h1aff
`define MMDEC_DESC1_LO    16'h1a80
`define MMDEC_RAM_LO      16'h1c00
`define MMDEC_RAM_HI      16'h2bff
`define MMDEC_RAM1_LO     16'h2400
`define MMDEC_MAIN_LO     16'h8000
`define MMDEC_MAIN_HI     16'hffff
`define MMDEC_VECT_LO     16'hff80
`define MMDEC_SNMI_VECT   16'hfffc
`define MMDEC_BOOT_SHIFT  9
`define MMDEC_INFO_SHIFT  7
`define MMDEC_MAIN_SHIFT  9
`define MMDEC_VMA_INDEX   8'h0c
`define MMDEC_RAM_PD_RST  2'h0
`define MMDEC_LOCKA_RST   1'b1

`endif

// File: mmdec_pkg.sv
/*
 Types shared by the memory map decoder.
 Assumes mmdec_map.svh sits in the same folder.
*/
package mmdec_pkg;
	typedef enum logic [3:0] {
		MMDEC_R_NONE   = 4'h0,
		MMDEC_R_PERIPH = 4'h1,
		MMDEC_R_BOOT   = 4'h2,
		MMDEC_R_INFO   = 4'h3,
		MMDEC_R_DESC   = 4'h4,
		MMDEC_R_RAM    = 4'h5,
		MMDEC_R_MAIN   = 4'h6
	} mmdec_region_t;

	typedef enum logic [2:0] {
		MMDEC_OP_NONE  = 3'h0,
		MMDEC_OP_PROG  = 3'h1,
		MMDEC_OP_SEG   = 3'h2,
		MMDEC_OP_MASS  = 3'h3,
		MMDEC_OP_ALL   = 3'h4
	} mmdec_flash_op_t;

	typedef enum logic [1:0] {
		MMDEC_W_BYTE = 2'h0,
		MMDEC_W_WORD = 2'h1,
		MMDEC_W_LONG = 2'h2
	} mmdec_width_t;
endpackage

// File: mmdec_ram_power.sv
/*
 RAM sector power control: off, retention or active for each sector.
 Assumes the decoder supplies one-cycle access strobes per sector.
*/
`timescale 1ns/1ps
`include "mmdec_map.svh"

module mmdec_ram_power #(
	parameter int SECTORS = 2
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic [SECTORS-1:0] sectorOff,
	input  wire logic [SECTORS-1:0] sectorHit,
	output logic      [SECTORS-1:0] sectorActive_reg,
	output logic      [SECTORS-1:0] sectorRetain_reg,
	output logic      [SECTORS-1:0] sectorClear_reg
);
	// Disabled sector loses data; clear pulse tells the array to drop it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sectorActive_reg <= '0;
			sectorRetain_reg <= '1;
			sectorClear_reg  <= '0;
		end else begin
			sectorActive_reg <= sectorHit & ~sectorOff; // RQ15
			sectorRetain_reg <= ~sectorHit & ~sectorOff; // RQ15
			sectorClear_reg  <= sectorOff & (sectorRetain_reg | sectorActive_reg); // RQ14
		end
	end

	property p_idle_retains;
		@(posedge sys_clk) disable iff (rst)
		!sectorHit[0] && !sectorOff[0] |=> sectorRetain_reg[0] && !sectorActive_reg[0];
	endproperty
	a_idle_retains: assert property (p_idle_retains) // RQ15
		else $error("Idle sector not in retention");
	property p_off_drops;
		@(posedge sys_clk) disable iff (rst)
		sectorOff[0] |=> !sectorRetain_reg[0] && !sectorActive_reg[0];
	endproperty
	a_off_drops: assert property (p_off_drops) // RQ14
		else $error("Disabled sector still powered");
endmodule // mmdec_ram_power

// File: mmdec_decoder.sv
/*
 Memory map decoder with region selects, vacant access event, flash
 program and erase qualification, and RAM sector power control.
 Assumes one bus master per cycle, all inputs synchronous to sys_clk.
*/
// Operation
// RQ1: Main flash 32 kB at 8000h-FFFFh, top 128 bytes are vectors.
// RQ2: RAM sector 1 at 2400h-2BFFh, sector 0 at 1C00h-23FFh.
// RQ3: Two 128-byte descriptor areas, 1A80h-1AFFh and 1A00h-1A7Fh.
// RQ4: Four 128-byte info segments, A at top 19FFh down to D at 1800h.
// RQ5: Four 512-byte boot sectors 3..0 over 1000h-17FFh, 3 highest.
// RQ6: Addresses 0 through FFFh go to peripheral space.
// RQ7: Access to unmapped address raises vacant access event.
// RQ8: CPU flash writes in byte, word or long-word size.
// RQ9: Debug path (four- or two-wire) may also program flash.
// RQ10: Main flash erased in 512-byte segments.
// RQ11: Erase one main segment or mass erase all main segments.
// RQ12: Erase one info segment, or all info with all main.
// RQ13: Info segment A has its own independent lock.
// RQ14: Each RAM sector can be disabled, losing its contents.
// RQ15: Unaccessed RAM sectors drop into retention automatically.
// RQ16: Vacant access flag sits in system NMI group, vector FFFCh.
// RQ17: CPU fetch from peripheral space causes system reset.
// RQ18: Exactly one select per mapped address, none when unmapped. Vector addresses raise vectorSel_reg with mainSel_reg.
// RQ19: Locked segment A ignores program and erase requests.
`timescale 1ns/1ps
`include "mmdec_map.svh"

module mmdec_decoder #(
	parameter int MAIN_SEGS = 64
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   cpuReq,
	input  wire logic                   cpuFetch,
	input  wire logic [15:0]            cpuAddr,
	input  wire logic                   dbgReq,
	input  wire logic [15:0]            dbgAddr,
	input  wire logic                   dbgSerial,
	input  wire logic                   flashReq,
	input  wire mmdec_pkg::mmdec_flash_op_t flashOp,
	input  wire mmdec_pkg::mmdec_width_t    flashWidth,
	input  wire logic                   flashFromDbg,
	input  wire logic                   lockASet,
	input  wire logic                   lockAClr,
	input  wire logic [1:0]             ramOff,
	input  wire logic                   vacantClr,
	output logic                        periphSel_reg,
	output logic [3:0]                  bootSel_reg,
	output logic [3:0]                  infoSel_reg,
	output logic [1:0]                  descSel_reg,
	output logic [1:0]                  ramSel_reg,
	output logic                        mainSel_reg,
	output logic                        vectorSel_reg,
	output logic                        vacant_access_flag_reg,
	output logic                        snmiPending_reg,
	output logic [7:0]                  system_nmi_vector_index_reg,
	output logic                        fetchReset_reg,
	output logic                        flashGo_reg,
	output mmdec_pkg::mmdec_flash_op_t  flashCmd_reg,
	output logic [3:0]                  flashByteEn_reg,
	output logic [15:0]                 eraseBase_reg,
	output logic [3:0]                  infoErase_reg,
	output logic                        mainEraseAll_reg,
	output logic                        dbgPort_reg,
	output logic                        lockA_reg,
	output logic [1:0]                  ramActive_reg,
	output logic [1:0]                  ramRetain_reg,
	output logic [1:0]                  ramClear_reg
);
	logic [15:0]                   addr;
	logic                          req;
	mmdec_pkg::mmdec_region_t      region;
	logic                          flashOk;
	logic [1:0]                    ramHit;

	function automatic mmdec_pkg::mmdec_region_t decode(input logic [15:0] a);
		if (a <= `MMDEC_PERIPH_HI) // RQ6
			decode = mmdec_pkg::MMDEC_R_PERIPH;
		else if (a <= `MMDEC_BOOT_HI) // RQ5
			decode = mmdec_pkg::MMDEC_R_BOOT;
		else if (a <= `MMDEC_INFO_HI) // RQ4
			decode = mmdec_pkg::MMDEC_R_INFO;
		else if (a <= `MMDEC_DESC_HI) // RQ3
			decode = mmdec_pkg::MMDEC_R_DESC;
		else if (a >= `MMDEC_RAM_LO && a <= `MMDEC_RAM_HI) // RQ2
			decode = mmdec_pkg::MMDEC_R_RAM;
		else if (a >= `MMDEC_MAIN_LO) // RQ1
			decode = mmdec_pkg::MMDEC_R_MAIN;
		else
			decode = mmdec_pkg::MMDEC_R_NONE; // RQ7
	endfunction

	function automatic logic [3:0] onehot4(input logic [1:0] i);
		onehot4 = 4'h1 << i;
	endfunction

	// CPU wins when both masters ask in one cycle
	assign req  = cpuReq | dbgReq;
	assign addr = cpuReq ? cpuAddr : dbgAddr;
	assign region = decode(addr);
	assign ramHit = (req && region == mmdec_pkg::MMDEC_R_RAM) ?
		((addr >= `MMDEC_RAM1_LO) ? 2'h2 : 2'h1) : 2'h0;

	// Region selects, one-hot by construction of the decode chain except vectorSel_reg, which rises with mainSel_reg
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periphSel_reg <= 1'b0;
			bootSel_reg   <= 4'h0;
			infoSel_reg   <= 4'h0;
			descSel_reg   <= 2'h0;
			ramSel_reg    <= 2'h0;
			mainSel_reg   <= 1'b0;
			vectorSel_reg <= 1'b0;
		end else begin
			periphSel_reg <= req && region == mmdec_pkg::MMDEC_R_PERIPH; // RQ18
			bootSel_reg   <= (req && region == mmdec_pkg::MMDEC_R_BOOT) ?
				onehot4(addr[10:9]) : 4'h0; // RQ5
			// Segment A is index 3 so the top address maps to A
			infoSel_reg   <= (req && region == mmdec_pkg::MMDEC_R_INFO) ?
				onehot4(addr[8:7]) : 4'h0; // RQ4
			descSel_reg   <= (req && region == mmdec_pkg::MMDEC_R_DESC) ?
				(addr[7] ? 2'h2 : 2'h1) : 2'h0; // RQ3
			ramSel_reg    <= ramHit; // RQ2
			mainSel_reg   <= req && region == mmdec_pkg::MMDEC_R_MAIN; // RQ1
			vectorSel_reg <= req && region == mmdec_pkg::MMDEC_R_MAIN &&
				addr >= `MMDEC_VECT_LO; // RQ1
		end
	end

	// Vacant access flag; a new event wins over the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vacant_access_flag_reg      <= 1'b0;
			snmiPending_reg             <= 1'b0;
			system_nmi_vector_index_reg <= 8'h00;
		end else begin
			if (req && region == mmdec_pkg::MMDEC_R_NONE) begin
				vacant_access_flag_reg      <= 1'b1; // RQ7
				snmiPending_reg             <= 1'b1; // RQ16
				system_nmi_vector_index_reg <= `MMDEC_VMA_INDEX; // RQ16
			end else if (vacantClr) begin
				vacant_access_flag_reg      <= 1'b0;
				snmiPending_reg             <= 1'b0;
				system_nmi_vector_index_reg <= 8'h00;
			end
		end
	end

	// Fetching code from registers is fatal, so reset the system
	always_ff @(posedge sys_clk) begin
		if (rst)
			fetchReset_reg <= 1'b0;
		else
			fetchReset_reg <= cpuReq && cpuFetch &&
				decode(cpuAddr) == mmdec_pkg::MMDEC_R_PERIPH; // RQ17
	end

	// Segment A lock; set wins over clear so a racing unlock is safe
	always_ff @(posedge sys_clk) begin
		if (rst)
			lockA_reg <= `MMDEC_LOCKA_RST;
		else if (lockASet)
			lockA_reg <= 1'b1; // RQ13
		else if (lockAClr)
			lockA_reg <= 1'b0; // RQ13
	end

	// Flash address comes from whichever master owns the request
	logic [15:0] fAddr;
	mmdec_pkg::mmdec_region_t fRegion;
	logic fInfoA;
	assign fAddr   = flashFromDbg ? dbgAddr : cpuAddr; // RQ9
	assign fRegion = decode(fAddr);
	assign fInfoA  = fRegion == mmdec_pkg::MMDEC_R_INFO && fAddr[8:7] == 2'h3;
	always_comb begin
		flashOk = 1'b0;
		case (flashOp)
			mmdec_pkg::MMDEC_OP_PROG,
			mmdec_pkg::MMDEC_OP_SEG:
				flashOk = (fRegion == mmdec_pkg::MMDEC_R_MAIN ||
					fRegion == mmdec_pkg::MMDEC_R_INFO ||
					fRegion == mmdec_pkg::MMDEC_R_BOOT) &&
					!(fInfoA && lockA_reg); // RQ19
			mmdec_pkg::MMDEC_OP_MASS,
			mmdec_pkg::MMDEC_OP_ALL:
				flashOk = 1'b1; // RQ11
			default:
				flashOk = 1'b0;
		endcase
	end

	// Flash command qualification and erase scope
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flashGo_reg      <= 1'b0;
			flashCmd_reg     <= mmdec_pkg::MMDEC_OP_NONE;
			flashByteEn_reg  <= 4'h0;
			eraseBase_reg    <= 16'h0000;
			infoErase_reg    <= 4'h0;
			mainEraseAll_reg <= 1'b0;
			dbgPort_reg      <= 1'b0;
		end else begin
			flashGo_reg      <= flashReq && flashOk;
			flashCmd_reg     <= (flashReq && flashOk) ? flashOp : mmdec_pkg::MMDEC_OP_NONE;
			dbgPort_reg      <= flashReq && flashFromDbg && dbgSerial; // RQ9
			case (flashWidth)
				mmdec_pkg::MMDEC_W_BYTE: flashByteEn_reg <= 4'h1 << fAddr[1:0]; // RQ8
				mmdec_pkg::MMDEC_W_WORD: flashByteEn_reg <= fAddr[1] ? 4'hc : 4'h3; // RQ8
				mmdec_pkg::MMDEC_W_LONG: flashByteEn_reg <= 4'hf; // RQ8
				default:                 flashByteEn_reg <= 4'h0;
			endcase
			// Info segments are 128 B, main and boot 512 B
			eraseBase_reg <= (fRegion == mmdec_pkg::MMDEC_R_INFO) ?
				{fAddr[15:`MMDEC_INFO_SHIFT], 7'h00} :
				{fAddr[15:`MMDEC_MAIN_SHIFT], 9'h000}; // RQ10
			mainEraseAll_reg <= flashReq && (flashOp == mmdec_pkg::MMDEC_OP_MASS ||
				flashOp == mmdec_pkg::MMDEC_OP_ALL); // RQ11
			if (flashReq && flashOp == mmdec_pkg::MMDEC_OP_ALL)
				infoErase_reg <= lockA_reg ? 4'h7 : 4'hf; // RQ12
			else if (flashReq && flashOp == mmdec_pkg::MMDEC_OP_SEG && flashOk &&
				fRegion == mmdec_pkg::MMDEC_R_INFO)
				infoErase_reg <= onehot4(fAddr[8:7]); // RQ12
			else
				infoErase_reg <= 4'h0;
		end
	end

	mmdec_ram_power #(
		.SECTORS (2)
	) u_ram_power (
		.sys_clk          (sys_clk),
		.rst              (rst),
		.sectorOff        (ramOff),
		.sectorHit        (ramHit),
		.sectorActive_reg (ramActive_reg),
		.sectorRetain_reg (ramRetain_reg),
		.sectorClear_reg  (ramClear_reg)
	); // RQ14

	property p_main;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr >= 16'h8000 |=> mainSel_reg && !periphSel_reg;
	endproperty
	a_main: assert property (p_main) // RQ1
		else $error("Main flash not selected");
	property p_ram;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h2400 |=> ramSel_reg == 2'h2;
	endproperty
	a_ram: assert property (p_ram) // RQ2
		else $error("RAM sector 1 wrong");
	property p_desc;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h1a7f |=> descSel_reg == 2'h1;
	endproperty
	a_desc: assert property (p_desc) // RQ3
		else $error("Descriptor select wrong");
	property p_infoa;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h19ff |=> infoSel_reg == 4'h8;
	endproperty
	a_infoa: assert property (p_infoa) // RQ4
		else $error("Info A select wrong");
	property p_boot;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h17ff |=> bootSel_reg == 4'h8;
	endproperty
	a_boot: assert property (p_boot) // RQ5
		else $error("Boot sector 3 select wrong");
	property p_periph;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h0fff |=> periphSel_reg;
	endproperty
	a_periph: assert property (p_periph) // RQ6
		else $error("Peripheral select missing");
	property p_vacant;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuAddr == 16'h2c00 |=> vacant_access_flag_reg &&
		system_nmi_vector_index_reg == 8'h0c && ramSel_reg == 2'h0;
	endproperty
	a_vacant: assert property (p_vacant) // RQ7
		else $error("Vacant access missed");
	property p_fetch;
		@(posedge sys_clk) disable iff (rst)
		cpuReq && cpuFetch && cpuAddr < 16'h1000 |=> fetchReset_reg;
	endproperty
	a_fetch: assert property (p_fetch) // RQ17
		else $error("Peripheral fetch no reset");
	property p_lock;
		@(posedge sys_clk) disable iff (rst)
		lockA_reg && flashReq && !flashFromDbg && flashOp == mmdec_pkg::MMDEC_OP_SEG &&
		cpuAddr[15:7] == 9'h033 |=> !flashGo_reg && infoErase_reg == 4'h0;
	endproperty
	a_lock: assert property (p_lock) // RQ19
		else $error("Locked segment A touched");
	property p_onesel;
		@(posedge sys_clk) disable iff (rst)
		$onehot0({periphSel_reg, |bootSel_reg, |infoSel_reg, |descSel_reg,
		|ramSel_reg, mainSel_reg, vacant_access_flag_reg && $changed(vacant_access_flag_reg)});
	endproperty
	a_onesel: assert property (p_onesel) // RQ18
		else $error("More than one select");
	// Main erase base must sit on a segment start inside the bank
	property p_segnum;
		@(posedge sys_clk) disable iff (rst)
		flashGo_reg && eraseBase_reg >= `MMDEC_MAIN_LO |->
			eraseBase_reg[8:0] == 9'h000 &&
			(int'(eraseBase_reg) - int'(`MMDEC_MAIN_LO)) / 512 < MAIN_SEGS;
	endproperty
	a_segnum: assert property (p_segnum) // RQ10
		else $error("Erase base outside main segments");
endmodule // mmdec_decoder

// File: mmdec_bus_model.sv
/*
 CPU and debug bus master model for the memory map decoder.
 Assumes the bench calls access() and nothing else drives these lines.
*/
`timescale 1ns/1ps

module mmdec_bus_model (
	input  wire logic        sys_clk,
	output logic             cpuReq,
	output logic             cpuFetch,
	output logic [15:0]      cpuAddr,
	output logic             dbgReq,
	output logic [15:0]      dbgAddr
);
	initial begin
		cpuReq = 1'b0;
		cpuFetch = 1'b0;
		cpuAddr = 16'h5a5a;
		dbgReq = 1'b0;
		dbgAddr = 16'ha5a5;
	end

	// Released address lines flip, so a stale address always differs from the one just driven
	task automatic access(input logic [15:0] a, input logic fetch, input logic dbg);
		@(posedge sys_clk);
		#1;
		cpuReq = !dbg;
		cpuFetch = fetch & !dbg;
		dbgReq = dbg;
		if (dbg) dbgAddr = a;
		else cpuAddr = a;
		@(posedge sys_clk);
		#1;
		cpuReq = 1'b0;
		cpuFetch = 1'b0;
		dbgReq = 1'b0;
		cpuAddr = ~cpuAddr;
		dbgAddr = ~dbgAddr;
	endtask
endmodule // mmdec_bus_model

// File: tb_top.sv
/*
 Self-checking bench for the memory map decoder.
 Assumes the bus model drives the CPU and debug request lines.
*/
`timescale 1ns/1ps

module tb_top;
	logic sys_clk, rst, cpuReq, cpuFetch, dbgReq, dbgSerial, flashReq, flashFromDbg;
	logic lockASet, lockAClr, vacantClr, periphSel_reg, mainSel_reg, vectorSel_reg;
	logic vacant_access_flag_reg, snmiPending_reg, fetchReset_reg, flashGo_reg;
	logic mainEraseAll_reg, dbgPort_reg, lockA_reg;
	logic [15:0] cpuAddr, dbgAddr, eraseBase_reg;
	logic [7:0] system_nmi_vector_index_reg;
	logic [3:0] bootSel_reg, infoSel_reg, flashByteEn_reg, infoErase_reg;
	logic [1:0] ramOff, descSel_reg, ramSel_reg, ramActive_reg, ramRetain_reg, ramClear_reg;
	mmdec_pkg::mmdec_flash_op_t flashOp, flashCmd_reg;
	mmdec_pkg::mmdec_width_t    flashWidth;
	int err_count = 0;
	int num_checks = 0;

	mmdec_bus_model bus (.sys_clk(sys_clk), .cpuReq(cpuReq), .cpuFetch(cpuFetch),
		.cpuAddr(cpuAddr), .dbgReq(dbgReq), .dbgAddr(dbgAddr));
	mmdec_decoder uut (.sys_clk(sys_clk), .rst(rst), .cpuReq(cpuReq), .cpuFetch(cpuFetch),
		.cpuAddr(cpuAddr), .dbgReq(dbgReq), .dbgAddr(dbgAddr), .dbgSerial(dbgSerial),
		.flashReq(flashReq), .flashOp(flashOp), .flashWidth(flashWidth),
		.flashFromDbg(flashFromDbg), .lockASet(lockASet), .lockAClr(lockAClr),
		.ramOff(ramOff), .vacantClr(vacantClr), .periphSel_reg(periphSel_reg),
		.bootSel_reg(bootSel_reg), .infoSel_reg(infoSel_reg), .descSel_reg(descSel_reg),
		.ramSel_reg(ramSel_reg), .mainSel_reg(mainSel_reg), .vectorSel_reg(vectorSel_reg),
		.vacant_access_flag_reg(vacant_access_flag_reg), .snmiPending_reg(snmiPending_reg),
		.system_nmi_vector_index_reg(system_nmi_vector_index_reg),
		.fetchReset_reg(fetchReset_reg), .flashGo_reg(flashGo_reg),
		.flashCmd_reg(flashCmd_reg), .flashByteEn_reg(flashByteEn_reg),
		.eraseBase_reg(eraseBase_reg), .infoErase_reg(infoErase_reg),
		.mainEraseAll_reg(mainEraseAll_reg), .dbgPort_reg(dbgPort_reg),
		.lockA_reg(lockA_reg), .ramActive_reg(ramActive_reg),
		.ramRetain_reg(ramRetain_reg), .ramClear_reg(ramClear_reg));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic pulse(ref logic s);
		@(posedge sys_clk);
		#1;
		s = 1'b1;
		@(posedge sys_clk);
		#1;
		s = 1'b0;
	endtask

	// Order: periph, boot 3..0, info A..D, desc hi/lo, ram 1/0, main, vector
	function automatic logic [14:0] expSel(input logic [15:0] a);
		logic [14:0] e;
		e = '0;
		if (a <= 16'h0fff) e[14] = 1'b1;
		else if (a <= 16'h17ff) e[10 + a[10:9]] = 1'b1;
		else if (a <= 16'h19ff) e[6 + a[8:7]] = 1'b1;
		else if (a <= 16'h1aff) e[4 + a[7]] = 1'b1;
		else if (a >= 16'h1c00 && a <= 16'h2bff) e[2 + (a >= 16'h2400)] = 1'b1;
		else if (a >= 16'h8000) e[1:0] = {1'b1, a >= 16'hff80};
		return e;
	endfunction

	task automatic flash(input logic [15:0] a, input mmdec_pkg::mmdec_flash_op_t op,
		input mmdec_pkg::mmdec_width_t w, input logic dbg);
		fork
			bus.access(a, 1'b0, dbg);
			begin
				@(posedge sys_clk);
				#1;
				flashReq = 1'b1;
				flashOp = op;
				flashWidth = w;
				flashFromDbg = dbg;
				@(posedge sys_clk);
				#1;
				flashReq = 1'b0;
			end
		join
	endtask

	// Boundaries of every region plus the holes between them
	task automatic t_map;
		logic [15:0] tbl[30] = '{16'h0000, 16'h0fff, 16'h1000, 16'h11ff, 16'h1200,
			16'h15ff, 16'h1600, 16'h17ff, 16'h1800, 16'h187f, 16'h1880, 16'h1900,
			16'h1980, 16'h19ff, 16'h1a00, 16'h1a7f, 16'h1a80, 16'h1aff, 16'h1b00,
			16'h1bff, 16'h1c00, 16'h23ff, 16'h2400, 16'h2bff, 16'h2c00, 16'h7fff,
			16'h8000, 16'hff7f, 16'hff80, 16'hffff};
		// Each address goes out once from each master
		for (int m = 0; m < 2; m++) begin
			foreach (tbl[i]) begin
				bus.access(tbl[i], 1'b0, i[0] ^ m[0]);
				chk({periphSel_reg, bootSel_reg, infoSel_reg, descSel_reg, ramSel_reg,
					mainSel_reg, vectorSel_reg}, expSel(tbl[i]));
				chk({vacant_access_flag_reg, snmiPending_reg, system_nmi_vector_index_reg},
					(expSel(tbl[i]) == 15'h0) ? 10'h30c : 10'h000);
				if (expSel(tbl[i]) == 15'h0) begin
					pulse(vacantClr);
					chk(vacant_access_flag_reg, 1'b0);
				end
			end
		end
	endtask

	task automatic t_fetch;
		bus.access(16'h0800, 1'b1, 1'b0);
		chk(fetchReset_reg, 1'b1);
		bus.access(16'h0800, 1'b0, 1'b0);
		chk(fetchReset_reg, 1'b0);
		bus.access(16'h8000, 1'b1, 1'b0);
		chk(fetchReset_reg, 1'b0);
	endtask

	task automatic t_flash;
		flash(16'h8001, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk({flashGo_reg, flashCmd_reg, flashByteEn_reg}, 8'h92);
		flash(16'h8002, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_WORD, 1'b0);
		chk({flashGo_reg, flashByteEn_reg}, 5'h1c);
		flash(16'h8000, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_LONG, 1'b0);
		chk({flashGo_reg, flashByteEn_reg}, 5'h1f);
		for (int s = 0; s < 2; s++) begin
			dbgSerial = s[0];
			flash(16'h1200, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_WORD, 1'b1);
			chk({flashGo_reg, dbgPort_reg}, {1'b1, s[0]});
		end
		flash(16'h0400, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_WORD, 1'b0);
		chk(flashGo_reg, 1'b0);
		flash(16'h8234, mmdec_pkg::MMDEC_OP_SEG, mmdec_pkg::MMDEC_W_WORD, 1'b0);
		chk({flashGo_reg, eraseBase_reg}, 17'h18200);
		flash(16'h9000, mmdec_pkg::MMDEC_OP_MASS, mmdec_pkg::MMDEC_W_WORD, 1'b0);
		chk({flashGo_reg, mainEraseAll_reg, flashCmd_reg}, 5'h1b);
		flash(16'h1900, mmdec_pkg::MMDEC_OP_SEG, mmdec_pkg::MMDEC_W_WORD, 1'b0);
		chk({flashGo_reg, infoErase_reg}, 5'h14);
	endtask

	task automatic t_lock;
		flash(16'h19a0, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk(flashGo_reg, 1'b0);
		flash(16'h19a0, mmdec_pkg::MMDEC_OP_SEG, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk(flashGo_reg, 1'b0);
		flash(16'h1920, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk(flashGo_reg, 1'b1);
		flash(16'h8000, mmdec_pkg::MMDEC_OP_ALL, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk({flashGo_reg, mainEraseAll_reg, infoErase_reg}, 6'h37);
		pulse(lockAClr);
		chk(lockA_reg, 1'b0);
		flash(16'h19a0, mmdec_pkg::MMDEC_OP_PROG, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk(flashGo_reg, 1'b1);
		flash(16'h8000, mmdec_pkg::MMDEC_OP_ALL, mmdec_pkg::MMDEC_W_BYTE, 1'b0);
		chk({mainEraseAll_reg, infoErase_reg}, 5'h1f);
		pulse(lockASet);
		chk(lockA_reg, 1'b1);
	endtask

	task automatic t_ram;
		bus.access(16'h2400, 1'b0, 1'b0);
		chk({ramActive_reg, ramRetain_reg}, 4'h9);
		repeat (3) @(posedge sys_clk);
		#1;
		chk({ramActive_reg, ramRetain_reg}, 4'h3);
		ramOff = 2'h1;
		@(posedge sys_clk);
		#1;
		chk({ramClear_reg, ramRetain_reg}, 4'h6);
		bus.access(16'h1c00, 1'b0, 1'b0);
		chk({ramActive_reg, ramRetain_reg, ramClear_reg}, 6'h08);
		repeat (3) @(posedge sys_clk);
		#1;
		chk({ramActive_reg[0], ramRetain_reg[0]}, 2'h0);
		ramOff = 2'h0;
	endtask

	initial begin
		{rst, dbgSerial, flashReq, flashFromDbg, lockASet, lockAClr, vacantClr} = 7'h40;
		ramOff = 2'h0;
		flashOp = mmdec_pkg::MMDEC_OP_NONE;
		flashWidth = mmdec_pkg::MMDEC_W_BYTE;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk({lockA_reg, ramRetain_reg, vacant_access_flag_reg, flashGo_reg}, 5'h1c);
		t_map();
		t_fetch();
		t_flash();
		t_lock();
		t_ram();
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		final_report();
	end
endmodule // tb_top
